// file: design/fdm_far_alu.sv
// Functional notes
// - the operand is reached by a flat address covering every data memory section, not a banked one.
// - add-with-carry to accumulator sums acc, operand and carry into acc and sets all five arithmetic flags.
// - add-with-carry to memory sums acc, operand and carry into the operand and sets all five arithmetic flags.
// - add to accumulator sums acc and operand without carry into acc and sets all five arithmetic flags.
// - add to memory sums acc and operand without carry into the operand and sets all five arithmetic flags.
// - and to accumulator writes acc and operand anded into acc and changes only z.
// - and to memory writes acc and operand anded into the operand and changes only z.
// - byte clear writes zero to the operand and keeps all flags.
// - bit clear zeroes only the chosen bit of the operand and keeps all flags.
`timescale 1ns/1ps
`default_nettype none
`include "fdm_map.svh"
module fdm_far_alu (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address and data
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // flat byte array covering every data memory section
    logic [7:0] mem [0:`FDM_MEM_WORDS-1];
    // architectural state that software sees through the register map
    logic [7:0] acc;
    fdm_pkg::fdm_flags_t flags;
    // command latched by the go write; addr is loaded by the address register write instead
    logic [`FDM_AW-1:0] addr;
    logic [2:0] bit_sel;
    fdm_pkg::fdm_op_t op;
    logic busy;
    // a write half that arrives alone waits here for its partner
    logic aw_hold, w_hold;
    logic [7:0] held_awaddr;
    logic [31:0] held_wdata;
    logic [3:0] held_wstrb;

    // write address and data are caught independently, in either order
    assign s_axi_awready = ~aw_hold & ~s_axi_bvalid;
    assign s_axi_wready = ~w_hold & ~s_axi_bvalid;
    wire aw_now = aw_hold | s_axi_awvalid;
    wire w_now = w_hold | s_axi_wvalid;
    wire [7:0] wa = aw_hold ? held_awaddr : s_axi_awaddr;
    wire [31:0] wd = w_hold ? held_wdata : s_axi_wdata;
    wire [3:0] ws = w_hold ? held_wstrb : s_axi_wstrb;
    wire wr_fire = aw_now & w_now & ~s_axi_bvalid;
    wire wr_known = (wa == `FDM_OFF_CTRL) | (wa == `FDM_OFF_ADDR) | (wa == `FDM_OFF_ACC)
        | (wa == `FDM_OFF_STAT) | (wa == `FDM_OFF_MEMW);

    // hold halves of a write until both have arrived
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold <= 1'b0;
            w_hold <= 1'b0;
            held_awaddr <= 8'h00;
            held_wdata <= 32'h0;
            held_wstrb <= 4'h0;
        end else if (wr_fire) begin
            aw_hold <= 1'b0;
            w_hold <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold <= 1'b1;
                held_awaddr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold <= 1'b1;
                held_wdata <= s_axi_wdata;
                held_wstrb <= s_axi_wstrb;
            end
        end
    end

    // write response one cycle after both halves; unmapped gets slverr
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'b00;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_known ? 2'b00 : 2'b10;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // datapath: operand fetched combinationally from the flat array
    // the sum is split at bits 4 and 7 so the nibble carry and the carry into the sign fall out directly
    wire [7:0] opnd = mem[addr];
    wire use_c = (op == fdm_pkg::FDM_FAR_ADD_CARRY_TO_ACCUM) || (op == fdm_pkg::FDM_FAR_ADD_CARRY_TO_MEMORY);
    wire cin = use_c & flags.c;
    wire [4:0] lo = {1'b0, acc[3:0]} + {1'b0, opnd[3:0]} + {4'h0, cin};
    wire [3:0] hi = {1'b0, acc[6:4]} + {1'b0, opnd[6:4]} + {3'h0, lo[4]};
    wire [1:0] top = {1'b0, acc[7]} + {1'b0, opnd[7]} + {1'b0, hi[3]};
    wire [7:0] sum = {top[0], hi[2:0], lo[3:0]};
    wire [7:0] andv = acc & opnd;
    fdm_pkg::fdm_flags_t add_f;
    // flag equations for additions
    always_comb begin
        add_f.c = top[1];
        add_f.nibble_carry_flag = lo[4];
        add_f.z = (sum == 8'h00);
        add_f.arith_wrap_flag = top[1] ^ hi[3];
        add_f.signed_carry_flag = (top[1] ^ hi[3]) ^ sum[7];
    end

    // execute: one operation per go, taking one cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            acc <= `FDM_ACC_RST;
            flags <= `FDM_FLAGS_RST;
            busy <= 1'b0;
            op <= fdm_pkg::FDM_NOP;
            addr <= '0;
            bit_sel <= 3'h0;
        end else if (busy) begin
            busy <= 1'b0;
            case (op)
                fdm_pkg::FDM_FAR_ADD_CARRY_TO_ACCUM, fdm_pkg::FDM_FAR_ADD_TO_ACCUM: begin
                    acc <= sum;
                    flags <= add_f;
                end
                fdm_pkg::FDM_FAR_ADD_CARRY_TO_MEMORY, fdm_pkg::FDM_FAR_ADD_TO_MEMORY: begin
                    flags <= add_f;
                end
                fdm_pkg::FDM_FAR_AND_TO_ACCUM: begin
                    acc <= andv;
                    flags.z <= (andv == 8'h00);
                end
                fdm_pkg::FDM_FAR_AND_TO_MEMORY: begin
                    flags.z <= (andv == 8'h00);
                end
                default: begin
                end
            endcase
        end else if (wr_fire) begin
            // software writes are ignored while an operation runs
            if (wa == `FDM_OFF_CTRL && ws[0] && wd[`FDM_CTRL_GO]) begin
                busy <= 1'b1;
                op <= fdm_pkg::fdm_op_t'(wd[`FDM_CTRL_OP_LSB +: 4]);
                bit_sel <= wd[`FDM_CTRL_BIT_LSB +: 3];
            end
            if (wa == `FDM_OFF_ADDR && ws[0])
                addr <= wd[`FDM_AW-1:0];
            if (wa == `FDM_OFF_ACC && ws[0])
                acc <= wd[7:0];
            if (wa == `FDM_OFF_STAT && ws[0])
                flags <= wd[4:0];
        end
    end

    // memory array write port, no reset so it maps to ram
    // only byte lane 0 carries data; a write without wstrb[0] leaves the byte alone
    always_ff @(posedge aclk) begin
        if (busy) begin
            case (op)
                fdm_pkg::FDM_FAR_ADD_CARRY_TO_MEMORY, fdm_pkg::FDM_FAR_ADD_TO_MEMORY: mem[addr] <= sum;
                fdm_pkg::FDM_FAR_AND_TO_MEMORY: mem[addr] <= andv;
                fdm_pkg::FDM_FAR_CLEAR: mem[addr] <= 8'h00;
                fdm_pkg::FDM_FAR_CLEAR_BIT: mem[addr][bit_sel] <= 1'b0;
                default: begin
                end
            endcase
        end else if (wr_fire && wa == `FDM_OFF_MEMW && ws[0]) begin
            mem[addr] <= wd[7:0];
        end
    end

    // status word assembled from the field positions of the map
    logic [31:0] stat_word;
    always_comb begin
        stat_word = 32'h0;
        stat_word[`FDM_ST_C] = flags.c;
        stat_word[`FDM_ST_NIBBLE] = flags.nibble_carry_flag;
        stat_word[`FDM_ST_Z] = flags.z;
        stat_word[`FDM_ST_WRAP] = flags.arith_wrap_flag;
        stat_word[`FDM_ST_SIGNED] = flags.signed_carry_flag;
        stat_word[`FDM_ST_BUSY] = busy;
    end

    // read channel: one cycle latency, registered data
    // the byte window returns the operand at the address held when the read is taken
    assign s_axi_arready = ~s_axi_rvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= 2'b00;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= 2'b00;
            case (s_axi_araddr)
                `FDM_OFF_CTRL: s_axi_rdata <= {20'h0, 1'b0, bit_sel, op, 4'h0};
                `FDM_OFF_ADDR: s_axi_rdata <= {23'h0, addr};
                `FDM_OFF_ACC: s_axi_rdata <= {24'h0, acc};
                `FDM_OFF_STAT: s_axi_rdata <= stat_word;
                `FDM_OFF_MEMW: s_axi_rdata <= {24'h0, opnd};
                default: begin
                    s_axi_rdata <= 32'h0;
                    s_axi_rresp <= 2'b10;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule : fdm_far_alu
`default_nettype wire

// file: design/fdm_map.svh
`ifndef FDM_MAP_SVH
`define FDM_MAP_SVH
// register byte offsets
`define FDM_OFF_CTRL 8'h00
`define FDM_OFF_ADDR 8'h04
`define FDM_OFF_ACC 8'h08
`define FDM_OFF_STAT 8'h0c
`define FDM_OFF_MEMW 8'h10
// control word fields
`define FDM_CTRL_GO 0
`define FDM_CTRL_OP_LSB 4
`define FDM_CTRL_BIT_LSB 8
// status word fields
`define FDM_ST_C 0
`define FDM_ST_NIBBLE 1
`define FDM_ST_Z 2
`define FDM_ST_WRAP 3
`define FDM_ST_SIGNED 4
`define FDM_ST_BUSY 8
// reset values
`define FDM_ACC_RST 8'h00
`define FDM_FLAGS_RST 5'h00
// memory size
`define FDM_MEM_WORDS 512
`define FDM_AW 9
`endif

// file: design/fdm_pkg.sv
package fdm_pkg;
    typedef enum logic [3:0] {
        FDM_NOP,
        FDM_FAR_ADD_CARRY_TO_ACCUM,
        FDM_FAR_ADD_CARRY_TO_MEMORY,
        FDM_FAR_ADD_TO_ACCUM,
        FDM_FAR_ADD_TO_MEMORY,
        FDM_FAR_AND_TO_ACCUM,
        FDM_FAR_AND_TO_MEMORY,
        FDM_FAR_CLEAR,
        FDM_FAR_CLEAR_BIT
    } fdm_op_t;
    typedef struct packed {
        logic signed_carry_flag;
        logic arith_wrap_flag;
        logic z;
        logic nibble_carry_flag;
        logic c;
    } fdm_flags_t;
endpackage : fdm_pkg

// file: verif/fdm_far_alu_properties.sv
`timescale 1ns/1ps
`default_nettype none
module fdm_far_alu_chk (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // write channels
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // read channels
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // both halves of a write, and a read address, taken at one edge
    sequence s_wr; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence
    sequence s_rd; s_axi_arvalid && s_axi_arready; endsequence
    property p_b_next; s_wr |=> s_axi_bvalid; endproperty
    a_b_next: assert property (p_b_next) else $error("write response late");
    property p_r_next; s_rd |=> s_axi_rvalid; endproperty
    a_r_next: assert property (p_r_next) else $error("read response late");
    property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
    a_b_hold: assert property (p_b_hold) else $error("write response dropped");
    property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
    a_r_hold: assert property (p_r_hold) else $error("read response dropped");
    property p_w_block; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
    a_w_block: assert property (p_w_block) else $error("write taken while pending");
    property p_r_block; s_axi_rvalid |-> !s_axi_arready; endproperty
    a_r_block: assert property (p_r_block) else $error("read taken while pending");
    // unmapped reads give an error code and zero data
    property p_r_bad; s_rd ##0 (s_axi_araddr > 8'h10) |=> s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0; endproperty
    a_r_bad: assert property (p_r_bad) else $error("unmapped read not refused");
    property p_r_ok; s_rd ##0 (s_axi_araddr <= 8'h10 && s_axi_araddr[1:0] == 2'b00) |=> s_axi_rresp == 2'b00; endproperty
    a_r_ok: assert property (p_r_ok) else $error("mapped read refused");
endmodule : fdm_far_alu_chk
bind fdm_far_alu fdm_far_alu_chk u_chk (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp)
);
`default_nettype wire

// file: verif/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, a, m, r, ea, em;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs, bs;
    logic [4:0] f, ef;
    logic [2:0] b;
    int failures = 0, checked = 0, seed = 32'h9ceabbba, op, s, n;
    fdm_far_alu dut (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
    );
    // free running core clock
    initial forever #12.5 aclk = ~aclk;
    task automatic tally_and_finish();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : tally_and_finish
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            failures++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    // hang guard shared by both bus tasks
    task automatic guard();
        if (n == 64) begin
            failures++;
            tally_and_finish();
        end
    endtask : guard
    // each channel held until its own ready is sampled
    task automatic wr(input logic [7:0] ad, input logic [31:0] dt);
        s_axi_awaddr <= ad;
        s_axi_wdata <= dt;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 64; n++) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid === 1'b1) break;
        end
        guard();
        bs = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask : wr
    task automatic rd(input logic [7:0] ad);
        s_axi_araddr <= ad;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 64; n++) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1) break;
        end
        guard();
        d = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask : rd
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        // every operation code and two no-op codes, random operands spread over the whole flat space
        for (int i = 0; i < 50; i++) begin
            op = i % 10;
            s = $random(seed);
            wr(8'h04, {23'h0, s[8:0]});
            s = $random(seed);
            {a, m, f, b} = s[23:0];
            wr(8'h10, {24'h0, m});
            wr(8'h08, {24'h0, a});
            wr(8'h0c, {27'h0, f});
            wr(8'h00, {21'h0, b, op[3:0], 4'h1});
            chk({30'h0, bs}, 32'h0);
            ea = a;
            em = m;
            ef = f;
            s = a + m + ((op == 1 || op == 2) ? f[0] : 0);
            r = s[7:0];
            if (op >= 1 && op < 5) begin
                ef[0] = s[8];
                ef[1] = ((a & 15) + (m & 15) + ((op < 3) ? f[0] : 0)) > 15;
                ef[3] = (((a & 127) + (m & 127) + ((op < 3) ? f[0] : 0)) > 127) ^ s[8];
                ef[4] = ef[3] ^ r[7];
            end else if (op == 5 || op == 6) r = a & m;
            else if (op == 7) r = 8'h00;
            else if (op == 8) r = m & ~(8'h01 << b);
            if (op >= 1 && op < 7) ef[2] = (r == 8'h00);
            if (op == 1 || op == 3 || op == 5) ea = r;
            else if (op >= 2 && op <= 8) em = r;
            rd(8'h08);
            chk(d, {24'h0, ea});
            rd(8'h0c);
            chk(d, {27'h0, ef});
            rd(8'h10);
            chk(d, {24'h0, em});
        end
        $display("operation sweep done");
        wr(8'h20, 32'h0);
        chk({30'h0, bs}, 32'h2);
        $display("unmapped write done");
        rd(8'h20);
        chk(d, 32'h0);
        chk({30'h0, rs}, 32'h2);
        $display("unmapped read done");
        tally_and_finish();
    end
endmodule : testbench
`default_nettype wire
